// file: hw/swt_cfg.svh
`ifndef SWT_CFG_SVH
`define SWT_CFG_SVH

// Register offsets
`define SWT_ADDR_CTRL      8'h2D
`define SWT_ADDR_PRESCALE  8'h2E
`define SWT_ADDR_IVAL_HI   8'h2F
`define SWT_ADDR_IVAL_LO   8'h30
`define SWT_ADDR_DURATION  8'h31

// Reset values
`define SWT_CTRL_RST       8'h06
`define SWT_PRESCALE_RST   8'h00
`define SWT_IVAL_RST       8'h00
`define SWT_DURATION_RST   8'h00
`define SWT_RDATA_IDLE     8'h00

// Control bit positions
`define SWT_BIT_SINGLE     7
`define SWT_BIT_TARGET     6
`define SWT_BIT_POST_EN    5
`define SWT_BIT_AUTO_WAKE  4
`define SWT_BIT_RC_POLICY  3
`define SWT_BIT_CLK_SEL    2
`define SWT_BIT_GATING     1
`define SWT_BIT_SLEEP      0

// Prescaler fields
`define SWT_PS_POST_HI     7
`define SWT_PS_POST_LO     4
`define SWT_PS_WAKE_HI     3
`define SWT_PS_WAKE_LO     0

// Prescaler code table
`define SWT_PS_CODE_NODIV     4'h0
`define SWT_PS_CODE_LONG_MIN  4'h1
`define SWT_PS_CODE_LONG_MAX  4'h8
`define SWT_PS_CODE_SHORT_MIN 4'h9
`define SWT_PS_CODE_SHORT_MAX 4'hD
`define SWT_PS_DIV_ONE        15'h0001
`define SWT_PS_LONG_BASE      15'h0080
`define SWT_PS_SHORT_BASE     15'h0002
`define SWT_PS_DIV_DEFAULT    15'h4000

// Timer arithmetic
`define SWT_PS_STEP        15'h0001
`define SWT_TMR_STEP       17'h00001
`define SWT_IVAL_ADD       17'h00001
`define SWT_DUR_SUB        17'h00001

`endif

// file: hw/swt_pkg.sv
`include "swt_cfg.svh"

package swt_pkg;

  typedef enum logic [1:0] {
    SWT_AWAKE,
    SWT_ASLEEP,
    SWT_ACTIVE
  } swt_state_e;

  // Shared by both prescalers
  function automatic logic [14:0] swt_ps_div(input logic [3:0] code);
    logic [14:0] d;
    d = `SWT_PS_DIV_DEFAULT;
    if (code == `SWT_PS_CODE_NODIV) begin
      d = `SWT_PS_DIV_ONE;
    end else if (code <= `SWT_PS_CODE_LONG_MAX) begin
      d = `SWT_PS_LONG_BASE << (code - `SWT_PS_CODE_LONG_MIN);
    end else if (code <= `SWT_PS_CODE_SHORT_MAX) begin
      d = `SWT_PS_SHORT_BASE << (code - `SWT_PS_CODE_SHORT_MIN);
    end
    return d;
  endfunction

endpackage

// file: hw/swt_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface swt_tmr_if;
  logic        start;
  logic        run;
  logic        tick;
  logic [16:0] target;
  logic        expire;
  modport ctl (output start, output run, output tick, output target, input expire);
  modport tmr (input start, input run, input tick, input target, output expire);
endinterface

`default_nettype wire

// file: hw/swt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "swt_cfg.svh"

module swt_prescaler (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Source and control
  input  wire logic        src_tick,
  input  wire logic        clear,
  input  wire logic [14:0] div,
  // Divided tick
  output var  logic        out_tick_ff
);

  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;
  logic        nxt_out_tick;

  always_comb begin
    nxt_cnt      = cnt_ff;
    nxt_out_tick = 1'b0;
    if (clear) begin
      nxt_cnt = '0;
    end else if (src_tick) begin
      // Compare with >= so a smaller divider taken mid-count still wraps
      if (cnt_ff >= div - `SWT_PS_STEP) begin
        nxt_cnt      = '0;
        nxt_out_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + `SWT_PS_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff      <= '0;
      out_tick_ff <= 1'b0;
    end else begin
      cnt_ff      <= nxt_cnt;
      out_tick_ff <= nxt_out_tick;
    end
  end

endmodule // swt_prescaler

`default_nettype wire

// file: hw/swt_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "swt_cfg.svh"

module swt_timer (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control side
  swt_tmr_if.tmr    bus
);

  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;
  logic        expire_ff;
  logic        nxt_expire;

  assign bus.expire = expire_ff;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_expire = 1'b0;
    if (bus.start) begin
      nxt_cnt = '0;
    end else if (bus.run && bus.tick) begin
      if (cnt_ff + `SWT_TMR_STEP >= bus.target) begin
        nxt_cnt    = '0;
        nxt_expire = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + `SWT_TMR_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff    <= '0;
      expire_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      expire_ff <= nxt_expire;
    end
  end

endmodule // swt_timer

`default_nettype wire

// file: hw/swt_sleep_ctrl.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "swt_cfg.svh"

module swt_sleep_ctrl (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data_ff,
  // Timer clock pins
  input  wire logic       external_timer_clock_in,
  input  wire logic       rc_osc_clk_in,
  output var  logic       rc_osc_run_ff,
  // Radio side
  input  wire logic       tx_fifo_write,
  input  wire logic       sync_detect,
  output var  logic       radio_rx_start_ff,
  output var  logic       radio_tx_start_ff,
  output var  logic       tx_accept_irq_ff,
  // Sleep state
  output var  logic       sleep_active_ff,
  output var  logic       power_gate_ff
);

  swt_tmr_if wake_tmr ();
  swt_tmr_if post_tmr ();

  swt_pkg::swt_state_e state_ff;
  swt_pkg::swt_state_e nxt_state;

  logic [7:0]  ctrl_ff;
  logic [7:0]  nxt_ctrl;
  logic [7:0]  prescale_ff;
  logic [7:0]  ival_hi_ff;
  logic [7:0]  ival_lo_ff;
  logic [7:0]  duration_ff;
  logic [7:0]  nxt_rd_data;
  logic        wake_run_ff;
  logic        nxt_wake_run;
  logic        tx_pend_ff;
  logic        nxt_tx_pend;
  logic        nxt_rx_start;
  logic        nxt_tx_start;
  logic        nxt_tx_irq;
  logic        wake_start;
  logic        post_start;
  logic        leaving;
  logic        wake_event;
  logic        ctrl_wr;
  logic        src_tick;
  logic        wake_ps_tick;
  logic        post_ps_tick;
  logic [1:0]  pin_in;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic [1:0]  sync3_ff;
  logic [1:0]  stable_ff;
  logic [1:0]  pin_rise;

  assign pin_in = {rc_osc_clk_in, external_timer_clock_in};
  // Three stages; a change counts once the last two agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_ff[gi]  <= 1'b0;
          sync2_ff[gi]  <= 1'b0;
          sync3_ff[gi]  <= 1'b0;
          stable_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            stable_ff[gi] <= sync3_ff[gi];
          end
        end
      end
      assign pin_rise[gi] = (sync2_ff[gi] == sync3_ff[gi]) && sync3_ff[gi] && !stable_ff[gi];
    end
  endgenerate

  // A stopped RC oscillator gives no edges, which is why the post timer stalls
  assign src_tick = ctrl_ff[`SWT_BIT_CLK_SEL] ? (pin_rise[1] && rc_osc_run_ff) : pin_rise[0];

  swt_prescaler u_wake_ps (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .src_tick    (src_tick),
    .clear       (wake_start),
    .div         (swt_pkg::swt_ps_div(prescale_ff[`SWT_PS_WAKE_HI:`SWT_PS_WAKE_LO])),
    .out_tick_ff (wake_ps_tick)
  );

  swt_prescaler u_post_ps (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .src_tick    (src_tick),
    .clear       (post_start),
    .div         (swt_pkg::swt_ps_div(prescale_ff[`SWT_PS_POST_HI:`SWT_PS_POST_LO])),
    .out_tick_ff (post_ps_tick)
  );

  assign wake_tmr.start  = wake_start;
  assign wake_tmr.run    = wake_run_ff && ctrl_ff[`SWT_BIT_AUTO_WAKE];
  assign wake_tmr.tick   = wake_ps_tick;
  assign wake_tmr.target = {1'b0, ival_hi_ff, ival_lo_ff} + `SWT_IVAL_ADD;
  assign post_tmr.start  = post_start;
  assign post_tmr.run    = (state_ff == swt_pkg::SWT_ACTIVE);
  assign post_tmr.tick   = post_ps_tick;
  assign post_tmr.target = {9'h000, duration_ff} - `SWT_DUR_SUB;

  swt_timer u_wake_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (wake_tmr.tmr)
  );

  swt_timer u_post_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (post_tmr.tmr)
  );

  assign ctrl_wr    = wr_en && (addr == `SWT_ADDR_CTRL);
  assign wake_event = (state_ff == swt_pkg::SWT_ASLEEP) && ctrl_ff[`SWT_BIT_SLEEP] &&
                      wake_tmr.expire && ctrl_ff[`SWT_BIT_AUTO_WAKE];

  // Sleep state machine
  always_comb begin
    nxt_state    = state_ff;
    wake_start   = 1'b0;
    post_start   = 1'b0;
    nxt_rx_start = 1'b0;
    nxt_tx_start = 1'b0;
    unique case (state_ff)
      swt_pkg::SWT_AWAKE: begin
        if (ctrl_ff[`SWT_BIT_SLEEP]) begin
          nxt_state  = swt_pkg::SWT_ASLEEP;
          wake_start = 1'b1;
        end
      end
      swt_pkg::SWT_ASLEEP: begin
        if (!ctrl_ff[`SWT_BIT_SLEEP]) begin
          nxt_state = swt_pkg::SWT_AWAKE;
        end else if (wake_event) begin
          nxt_rx_start = !ctrl_ff[`SWT_BIT_TARGET];
          nxt_tx_start = ctrl_ff[`SWT_BIT_TARGET];
          if (ctrl_ff[`SWT_BIT_POST_EN]) begin
            nxt_state  = swt_pkg::SWT_ACTIVE;
            post_start = 1'b1;
          end else begin
            nxt_state = swt_pkg::SWT_AWAKE;
          end
        end
      end
      swt_pkg::SWT_ACTIVE: begin
        if (ctrl_ff[`SWT_BIT_SLEEP] || post_tmr.expire) begin
          // Transmit has no early exit, so the host must send in time
          nxt_state = swt_pkg::SWT_ASLEEP;
        end else if (!ctrl_ff[`SWT_BIT_TARGET] && sync_detect) begin
          nxt_state = swt_pkg::SWT_AWAKE;
        end
      end
    endcase
  end

  assign leaving = (state_ff == swt_pkg::SWT_ASLEEP) && (nxt_state != swt_pkg::SWT_ASLEEP);
  // Control register; hardware sleep bit updates win over a same-cycle write
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = wr_data;
    end
    if (wake_event) begin
      nxt_ctrl[`SWT_BIT_SLEEP] = 1'b0;
    end
    if ((state_ff == swt_pkg::SWT_ACTIVE) && post_tmr.expire) begin
      nxt_ctrl[`SWT_BIT_SLEEP] = 1'b1;
    end
  end

  // Wake timer run flag and pending transmit notice
  always_comb begin
    nxt_wake_run = wake_run_ff;
    if (wake_start) begin
      nxt_wake_run = 1'b1;
    end else if (wake_tmr.expire && ctrl_ff[`SWT_BIT_SINGLE]) begin
      nxt_wake_run = 1'b0;
    end
    nxt_tx_irq  = leaving && (tx_pend_ff || tx_fifo_write);
    nxt_tx_pend = !leaving && (tx_pend_ff || (tx_fifo_write && (state_ff == swt_pkg::SWT_ASLEEP)));
  end

  // Read data
  always_comb begin
    nxt_rd_data = `SWT_RDATA_IDLE;
    if (rd_en) begin
      unique case (addr)
        `SWT_ADDR_CTRL:     nxt_rd_data = ctrl_ff;
        `SWT_ADDR_PRESCALE: nxt_rd_data = prescale_ff;
        `SWT_ADDR_IVAL_HI:  nxt_rd_data = ival_hi_ff;
        `SWT_ADDR_IVAL_LO:  nxt_rd_data = ival_lo_ff;
        `SWT_ADDR_DURATION: nxt_rd_data = duration_ff;
        default:            nxt_rd_data = `SWT_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff          <= swt_pkg::SWT_AWAKE;
      ctrl_ff           <= `SWT_CTRL_RST;
      prescale_ff       <= `SWT_PRESCALE_RST;
      ival_hi_ff        <= `SWT_IVAL_RST;
      ival_lo_ff        <= `SWT_IVAL_RST;
      duration_ff       <= `SWT_DURATION_RST;
      rd_data_ff        <= `SWT_RDATA_IDLE;
      wake_run_ff       <= 1'b0;
      tx_pend_ff        <= 1'b0;
      tx_accept_irq_ff  <= 1'b0;
      radio_rx_start_ff <= 1'b0;
      radio_tx_start_ff <= 1'b0;
      sleep_active_ff   <= 1'b0;
      power_gate_ff     <= 1'b0;
      rc_osc_run_ff     <= 1'b1;
    end else begin
      state_ff          <= nxt_state;
      ctrl_ff           <= nxt_ctrl;
      if (wr_en && (addr == `SWT_ADDR_PRESCALE)) begin
        prescale_ff <= wr_data;
      end
      if (wr_en && (addr == `SWT_ADDR_IVAL_HI)) begin
        ival_hi_ff <= wr_data;
      end
      if (wr_en && (addr == `SWT_ADDR_IVAL_LO)) begin
        ival_lo_ff <= wr_data;
      end
      if (wr_en && (addr == `SWT_ADDR_DURATION)) begin
        duration_ff <= wr_data;
      end
      rd_data_ff        <= nxt_rd_data;
      wake_run_ff       <= nxt_wake_run;
      tx_pend_ff        <= nxt_tx_pend;
      tx_accept_irq_ff  <= nxt_tx_irq;
      radio_rx_start_ff <= nxt_rx_start;
      radio_tx_start_ff <= nxt_tx_start;
      sleep_active_ff   <= (nxt_state == swt_pkg::SWT_ASLEEP);
      power_gate_ff     <= (nxt_state == swt_pkg::SWT_ASLEEP) && nxt_ctrl[`SWT_BIT_GATING];
      rc_osc_run_ff     <= !nxt_ctrl[`SWT_BIT_RC_POLICY] || (nxt_state == swt_pkg::SWT_ASLEEP);
    end
  end

  sequence s_wake;
    wake_event;
  endsequence
  sequence s_post_end;
    (state_ff == swt_pkg::SWT_ACTIVE) && post_tmr.expire && !ctrl_ff[`SWT_BIT_SLEEP];
  endsequence

  property p_sleep_entry;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == swt_pkg::SWT_AWAKE) && ctrl_ff[`SWT_BIT_SLEEP] |=> sleep_active_ff ##1 sleep_active_ff;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_wake_rx;
    @(posedge ref_clk) disable iff (rst)
    s_wake ##0 !ctrl_ff[`SWT_BIT_TARGET] |=> radio_rx_start_ff && !radio_tx_start_ff && !sleep_active_ff;
  endproperty
  a_wake_rx: assert property (p_wake_rx) else $error("receive wake missing");

  property p_wake_tx;
    @(posedge ref_clk) disable iff (rst)
    s_wake ##0 ctrl_ff[`SWT_BIT_TARGET] |=> radio_tx_start_ff && !radio_rx_start_ff;
  endproperty
  a_wake_tx: assert property (p_wake_tx) else $error("transmit wake missing");

  property p_no_wake_disabled;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == swt_pkg::SWT_ASLEEP) && ctrl_ff[`SWT_BIT_SLEEP] && !ctrl_ff[`SWT_BIT_AUTO_WAKE] && !ctrl_wr
    |=> sleep_active_ff;
  endproperty
  a_no_wake_disabled: assert property (p_no_wake_disabled) else $error("woke while disabled");

  property p_post_start;
    @(posedge ref_clk) disable iff (rst)
    s_wake ##0 ctrl_ff[`SWT_BIT_POST_EN] |=> (state_ff == swt_pkg::SWT_ACTIVE);
  endproperty
  a_post_start: assert property (p_post_start) else $error("post timer not started");

  property p_post_sleep;
    @(posedge ref_clk) disable iff (rst)
    s_post_end |=> sleep_active_ff && ctrl_ff[`SWT_BIT_SLEEP];
  endproperty
  a_post_sleep: assert property (p_post_sleep) else $error("no return to sleep");

  property p_sync_stays;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == swt_pkg::SWT_ACTIVE) && !ctrl_ff[`SWT_BIT_SLEEP] && !post_tmr.expire &&
    !ctrl_ff[`SWT_BIT_TARGET] && sync_detect |=> (state_ff == swt_pkg::SWT_AWAKE);
  endproperty
  a_sync_stays: assert property (p_sync_stays) else $error("sync did not hold awake");

  property p_tx_irq;
    @(posedge ref_clk) disable iff (rst)
    leaving && tx_pend_ff |=> tx_accept_irq_ff ##1 !tx_accept_irq_ff;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("accept interrupt lost");

  property p_irq_not_asleep;
    @(posedge ref_clk) disable iff (rst)
    tx_accept_irq_ff |-> !sleep_active_ff;
  endproperty
  a_irq_not_asleep: assert property (p_irq_not_asleep) else $error("interrupt during sleep");

  property p_single_shot;
    @(posedge ref_clk) disable iff (rst)
    wake_tmr.expire && ctrl_ff[`SWT_BIT_SINGLE] && !wake_start |=> !wake_run_ff;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("one shot kept running");

  property p_reset_ctrl;
    @(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> (ctrl_ff == `SWT_CTRL_RST);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("bad control reset");

  property p_gating;
    @(posedge ref_clk) disable iff (rst)
    power_gate_ff |-> sleep_active_ff && ctrl_ff[`SWT_BIT_GATING];
  endproperty
  a_gating: assert property (p_gating) else $error("power gated while awake");

endmodule // swt_sleep_ctrl

`default_nettype wire

// file: verification/test_sleep_wakeup_timer_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "swt_cfg.svh"

module test_sleep_wakeup_timer_control;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic       external_timer_clock_in = 1'b0;
  logic       rc_osc_clk_in = 1'b0;
  logic       tx_fifo_write = 1'b0;
  logic       sync_detect = 1'b0;
  wire  logic [7:0] rd_data_ff;
  wire  logic rc_osc_run_ff, radio_rx_start_ff, radio_tx_start_ff;
  wire  logic tx_accept_irq_ff, sleep_active_ff, power_gate_ff;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ph = 0;
  bit ext_run = 1'b1;
  bit rc_run = 1'b0;
  int cyc, ival, dv, n;
  // No crystal oscillator on this bench, so the undivided post prescaler is allowed
  int pcs[3] = '{0, 9, 10};
  logic [3:0] codes[7] = '{4'h0, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h1};

  swt_sleep_ctrl dut_u (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_ff(rd_data_ff), .external_timer_clock_in(external_timer_clock_in),
    .rc_osc_clk_in(rc_osc_clk_in), .rc_osc_run_ff(rc_osc_run_ff), .tx_fifo_write(tx_fifo_write),
    .sync_detect(sync_detect), .radio_rx_start_ff(radio_rx_start_ff), .radio_tx_start_ff(radio_tx_start_ff),
    .tx_accept_irq_ff(tx_accept_irq_ff), .sleep_active_ff(sleep_active_ff), .power_gate_ff(power_gate_ff)
  );

  always #50 ref_clk = ~ref_clk;

  // Slow source clocks, 8 cycles a period; each stands still when switched off
  always @(posedge ref_clk) begin
    ph <= (ph == 7) ? 0 : ph + 1;
    external_timer_clock_in <= ext_run && (ph < 4);
    rc_osc_clk_in <= rc_run && (ph < 4);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  function automatic int div_of(input logic [3:0] c);
    case (c)
      4'h0: return 1;
      4'h9: return 2;
      4'hA: return 4;
      4'hB: return 8;
      4'hC: return 16;
      4'hD: return 32;
      default: return (c <= 4'h8) ? (128 << (c - 1)) : 16384;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rd_data_ff, e);
  endtask

  task automatic wait_lvl(input logic lvl, input int lim, output int c);
    c = 0;
    #1;
    while (sleep_active_ff !== lvl && c < lim) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask

  // Edge count to cycles: a source period and a half (12 cycles) of slack covers phase and sync lag
  task automatic wchk(input string nm, input int c, input int edges);
    chk(nm, (c >= edges * 8 - 12) && (c <= edges * 8 + 12), 1);
  endtask

  task automatic measure(input logic [7:0] ctrl, input int edges, input bit do_tx, output int c);
    wr(`SWT_ADDR_CTRL, ctrl | 8'h01);
    wait_lvl(1'b1, 6, c);
    chk("power gate", power_gate_ff, ctrl[1]);
    if (do_tx) begin
      @(posedge ref_clk);
      tx_fifo_write <= 1'b1;
      @(posedge ref_clk);
      tx_fifo_write <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq held in sleep", tx_accept_irq_ff, 0);
    end
    wait_lvl(1'b0, edges * 8 + 20, c);
  endtask

  initial begin
    void'($urandom(32'h52AE));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("rc run at reset", rc_osc_run_ff, 1);
    chk("asleep at reset", sleep_active_ff, 0);
    rchk(`SWT_ADDR_CTRL, 8'h06);
    for (int a = 8'h2E; a <= 8'h31; a++) rchk(a[7:0], 8'h00);
    $display("test reset values done");

    for (int a = 8'h2E; a <= 8'h31; a++) begin
      n = $urandom;
      if (a == 8'h2F) dv = n;
      wr(a[7:0], n[7:0]);
      rchk(a[7:0], n[7:0]);
    end
    wr(8'h40, 8'hFF);
    rchk(8'h40, 8'h00);
    rchk(`SWT_ADDR_IVAL_HI, dv[7:0]);
    $display("test register access done");

    wr(`SWT_ADDR_CTRL, 8'h03);
    wait_lvl(1'b1, 6, cyc);
    chk("sleep on write", sleep_active_ff, 1);
    chk("gated in sleep", power_gate_ff, 1);
    wr(`SWT_ADDR_CTRL, 8'h02);
    wait_lvl(1'b0, 6, cyc);
    chk("awake on write", sleep_active_ff, 0);
    chk("ungated awake", power_gate_ff, 0);
    $display("test manual sleep done");

    ival = 2 + ($urandom % 2);
    wr(`SWT_ADDR_IVAL_HI, 8'h00);
    wr(`SWT_ADDR_IVAL_LO, ival[7:0]);
    foreach (codes[i]) begin
      wr(`SWT_ADDR_PRESCALE, {4'h0, codes[i]});
      measure(8'h10, div_of(codes[i]) * (ival + 1), 1'b0, cyc);
      wchk("wake interval", cyc, div_of(codes[i]) * (ival + 1));
      chk("rx start", radio_rx_start_ff, 1);
      chk("no tx start", radio_tx_start_ff, 0);
      rchk(`SWT_ADDR_CTRL, 8'h10);
    end
    repeat (100) @(posedge ref_clk);
    #1;
    chk("stays awake", sleep_active_ff, 0);
    $display("test wake interval done");

    wr(`SWT_ADDR_PRESCALE, 8'h09);
    ext_run = 1'b0;
    rc_run = 1'b1;
    measure(8'h14, 2 * (ival + 1), 1'b0, cyc);
    wchk("rc sourced wake", cyc, 2 * (ival + 1));
    measure(8'h10, 2 * (ival + 1), 1'b0, cyc);
    chk("no ext edges", sleep_active_ff, 1);
    measure(8'h04, 2 * (ival + 1), 1'b0, cyc);
    chk("wake disabled", sleep_active_ff, 1);
    wr(`SWT_ADDR_CTRL, 8'h00);
    ext_run = 1'b1;
    rc_run = 1'b0;
    $display("test clock source done");

    // Post timer off here, so the transmit data meet no deadline
    measure(8'h50, 2 * (ival + 1), 1'b1, cyc);
    chk("tx start", radio_tx_start_ff, 1);
    chk("no rx start", radio_rx_start_ff, 0);
    n = 0;
    repeat (3) begin
      n += (tx_accept_irq_ff === 1'b1);
      @(posedge ref_clk);
      #1;
    end
    chk("irq after wake", n, 1);
    $display("test transmit wake done");

    wr(`SWT_ADDR_DURATION, 8'h03);
    foreach (pcs[i]) begin
      dv = div_of(pcs[i]);
      wr(`SWT_ADDR_PRESCALE, {pcs[i][3:0], 4'h9});
      measure(8'h30, 2 * (ival + 1), 1'b0, cyc);
      wait_lvl(1'b1, dv * 16 + 20, cyc);
      wchk("post window", cyc, dv * 2);
      rchk(`SWT_ADDR_CTRL, 8'h31);
      // Wake timer kept counting through the window; next expiry after it wakes
      n = 2 * (ival + 1);
      while (n <= dv * 2) n += 2 * (ival + 1);
      wait_lvl(1'b0, (n - dv * 2) * 8 + 20, cyc);
      wchk("rewake", cyc, n - dv * 2);
      @(posedge ref_clk);
      sync_detect <= 1'b1;
      @(posedge ref_clk);
      sync_detect <= 1'b0;
      repeat (dv * 16 + 40) @(posedge ref_clk);
      #1;
      chk("sync keeps awake", sleep_active_ff, 0);
    end
    $display("test post wake timer done");

    wr(`SWT_ADDR_PRESCALE, 8'h99);
    measure(8'hB0, 2 * (ival + 1), 1'b0, cyc);
    wchk("one shot wake", cyc, 2 * (ival + 1));
    wait_lvl(1'b1, 60, cyc);
    wait_lvl(1'b0, 2 * (ival + 1) * 16 + 20, cyc);
    chk("one shot stays asleep", sleep_active_ff, 1);
    wr(`SWT_ADDR_CTRL, 8'h00);
    $display("test single shot done");

    wr(`SWT_ADDR_CTRL, 8'h08);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("rc off awake", rc_osc_run_ff, 0);
    wr(`SWT_ADDR_CTRL, 8'h09);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("rc on asleep", rc_osc_run_ff, 1);
    wr(`SWT_ADDR_CTRL, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("rc always on", rc_osc_run_ff, 1);
    $display("test rc policy done");
    end_sim();
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
endmodule // test_sleep_wakeup_timer_control

`default_nettype wire
